// ---- rtl/t16c_core.sv ----
// 16-bit timer core with its channel 0 capture/compare unit.
// Assumes tick_in and the channel 1/2 events come from clock_in logic.
`timescale 1ns/10ps
`default_nettype none
module t16c_core (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Timer tick and other channels
    input wire logic tick_in,
    input wire logic chan1_event_in,
    input wire logic chan2_event_in,
    // Channel 0 pin
    input wire logic chan0_pin_in,
    output logic chan0_pin_out,
    output logic chan0_pin_oe_out,
    // Shared with the other channels
    output logic [15:0] count_value_out,
    output logic [15:0] chan0_value_out,
    output logic count_down_out,
    output logic count_step_out,
    // Interrupt
    output logic irq_out
);
    typedef struct packed {
        logic [15:0] cnt;
        t16c_pkg::t16c_dir_t dir;
        logic [1:0] div;
        logic [1:0] mode;
        logic [3:0] flags;
        logic [7:0] ch0ctl;
        logic [15:0] cc0;
        logic [7:0] cc0_low_buf;
        logic [7:0] hi_latch;
        logic pin;
        logic [7:0] rdata;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
    } t16c_core_st_t;

    t16c_core_st_t st_ff;
    t16c_core_st_t nxt_st;

    function automatic logic hit(input logic strobe,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // Decoded controls and events

    logic run;
    logic pre_step;
    logic step;
    logic rise;
    logic fall;
    logic is_cmp;
    logic [2:0] cmp_mode;
    logic [1:0] cap_sel;
    logic chan_irq_mask;
    logic wr_cnt_low;
    logic [15:0] cnt_next;
    t16c_pkg::t16c_dir_t dir_next;
    logic ovf_ev;
    logic match_ev;
    logic zero_ev;
    logic cap_ev;
    logic ch0_ev;

    assign run = st_ff.mode != t16c_pkg::MODE_SUSPEND;
    assign step = run && pre_step;
    assign is_cmp = st_ff.ch0ctl[t16c_pkg::CH0_FUNC_BIT];
    assign cmp_mode = st_ff.ch0ctl[t16c_pkg::CH0_CMP_LSB +: 3];
    assign cap_sel = st_ff.ch0ctl[t16c_pkg::CH0_CAP_LSB +: 2];
    assign chan_irq_mask = st_ff.ch0ctl[t16c_pkg::CH0_IM_BIT];
    assign wr_cnt_low = hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CNT_LOW);

    t16c_prescale u_prescale (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .run_in(run),
        .div_sel_in(st_ff.div),
        .tick_in(tick_in),
        .step_out(pre_step)
    );

    t16c_pin_sync u_pin_sync (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .pin_in(chan0_pin_in),
        .rise_out(rise),
        .fall_out(fall)
    );

    // Counting step for the selected mode
    always_comb begin
        cnt_next = st_ff.cnt;
        dir_next = st_ff.dir;
        ovf_ev = 1'b0;
        if (step) begin
            unique case (st_ff.mode)
                t16c_pkg::MODE_FREE: begin
                    cnt_next = st_ff.cnt + 16'h0001;
                    ovf_ev = st_ff.cnt == t16c_pkg::CNT_MAX;
                end
                t16c_pkg::MODE_MODULO: begin
                    if (st_ff.cnt == st_ff.cc0) begin
                        cnt_next = t16c_pkg::RST_CNT;
                        ovf_ev = 1'b1;
                    end else begin
                        cnt_next = st_ff.cnt + 16'h0001;
                    end
                end
                t16c_pkg::MODE_UPDOWN: begin
                    if (st_ff.dir == t16c_pkg::T16C_UP) begin
                        // A zero top value parks the counter at zero
                        if (st_ff.cnt == st_ff.cc0) begin
                            if (st_ff.cc0 != t16c_pkg::RST_CNT) begin
                                cnt_next = st_ff.cnt - 16'h0001;
                                dir_next = t16c_pkg::T16C_DOWN;
                            end
                        end else begin
                            cnt_next = st_ff.cnt + 16'h0001;
                        end
                    end else begin
                        cnt_next = st_ff.cnt - 16'h0001;
                        if (st_ff.cnt == 16'h0001) begin
                            dir_next = t16c_pkg::T16C_UP;
                            ovf_ev = 1'b1;
                        end
                    end
                end
                default: begin
                    cnt_next = st_ff.cnt;
                end
            endcase
        end
    end

    assign match_ev = step && is_cmp && (cnt_next == st_ff.cc0);
    assign zero_ev = step && (cnt_next == t16c_pkg::RST_CNT);
    assign cap_ev = run && !is_cmp && ((cap_sel[0] && rise) ||
                                       (cap_sel[1] && fall));
    // In up/down mode the channel event moves to the zero turn
    assign ch0_ev = cap_ev ||
        ((st_ff.mode == t16c_pkg::MODE_UPDOWN) ? (zero_ev && is_cmp)
                                                : match_ev);

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.cnt = cnt_next;
        nxt_st.dir = dir_next;

        // Compare output actions
        if (match_ev) begin
            unique case (cmp_mode)
                t16c_pkg::CMP_SET: nxt_st.pin = 1'b1;
                t16c_pkg::CMP_CLEAR: nxt_st.pin = 1'b0;
                t16c_pkg::CMP_TOGGLE: nxt_st.pin = !st_ff.pin;
                t16c_pkg::CMP_SET_UP: begin
                    nxt_st.pin = (st_ff.dir == t16c_pkg::T16C_UP);
                end
                t16c_pkg::CMP_CLEAR_UP: begin
                    nxt_st.pin = (st_ff.dir == t16c_pkg::T16C_DOWN);
                end
                default: nxt_st.pin = st_ff.pin;
            endcase
        end else if (zero_ev && is_cmp &&
                     st_ff.mode != t16c_pkg::MODE_UPDOWN) begin
            if (cmp_mode == t16c_pkg::CMP_SET_UP) begin
                nxt_st.pin = 1'b0;
            end else if (cmp_mode == t16c_pkg::CMP_CLEAR_UP) begin
                nxt_st.pin = 1'b1;
            end
        end

        // Register writes
        if (wr_cnt_low) begin
            nxt_st.cnt = t16c_pkg::RST_CNT;
            nxt_st.dir = t16c_pkg::T16C_UP;
        end
        if (hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CTL)) begin
            nxt_st.div = reg_wdata_in[t16c_pkg::CTL_DIV_LSB +: 2];
            nxt_st.mode = reg_wdata_in[t16c_pkg::CTL_MODE_LSB +: 2];
            nxt_st.flags = st_ff.flags &
                reg_wdata_in[t16c_pkg::CTL_FLAG_LSB +: 4];
        end
        if (hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CH0CTL)) begin
            nxt_st.ch0ctl = reg_wdata_in;
        end
        // Low byte waits for the high byte so the pair changes at once
        if (hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CC0_LOW)) begin
            nxt_st.cc0_low_buf = reg_wdata_in;
        end
        if (hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CC0_HIGH)) begin
            nxt_st.cc0 = {reg_wdata_in, st_ff.cc0_low_buf};
        end
        if (hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_IRQ_MASK)) begin
            nxt_st.irq_mask = reg_wdata_in[1:0];
        end

        // Capture beats a same-cycle software write of the value
        if (cap_ev) begin
            nxt_st.cc0 = st_ff.cnt;
        end

        // Hardware sets win over software clears
        if (!wr_cnt_low) begin
            nxt_st.flags[0] = nxt_st.flags[0] | ovf_ev;
        end
        nxt_st.flags[1] = nxt_st.flags[1] | ch0_ev;
        nxt_st.flags[2] = nxt_st.flags[2] | chan1_event_in;
        nxt_st.flags[3] = nxt_st.flags[3] | chan2_event_in;

        // Interrupt status: cleared by read, set wins
        if (hit(reg_rd_in, reg_addr_in, t16c_pkg::ADDR_IRQ_STAT)) begin
            nxt_st.irq_stat = 2'h0;
        end
        if (ovf_ev && !wr_cnt_low) begin
            nxt_st.irq_stat[t16c_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (ch0_ev) begin
            nxt_st.irq_stat[t16c_pkg::IRQ_CH0_BIT] = 1'b1;
        end

        // Read data, valid only in the cycle after the strobe
        nxt_st.rdata = t16c_pkg::RST_BYTE;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                t16c_pkg::ADDR_CNT_LOW: begin
                    nxt_st.rdata = st_ff.cnt[7:0];
                    nxt_st.hi_latch = st_ff.cnt[15:8];
                end
                t16c_pkg::ADDR_CNT_HIGH: nxt_st.rdata = st_ff.hi_latch;
                t16c_pkg::ADDR_CTL: begin
                    nxt_st.rdata = {st_ff.flags, st_ff.div, st_ff.mode};
                end
                t16c_pkg::ADDR_CH0CTL: nxt_st.rdata = st_ff.ch0ctl;
                t16c_pkg::ADDR_CC0_LOW: nxt_st.rdata = st_ff.cc0[7:0];
                t16c_pkg::ADDR_CC0_HIGH: nxt_st.rdata = st_ff.cc0[15:8];
                t16c_pkg::ADDR_IRQ_STAT: begin
                    nxt_st.rdata = {6'h00, st_ff.irq_stat};
                end
                t16c_pkg::ADDR_IRQ_MASK: begin
                    nxt_st.rdata = {6'h00, st_ff.irq_mask};
                end
                default: nxt_st.rdata = t16c_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '0;
            st_ff.ch0ctl <= t16c_pkg::RST_CH0CTL;
            st_ff.irq_mask <= t16c_pkg::RST_IRQ_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata_out = st_ff.rdata;
    assign chan0_pin_out = st_ff.pin;
    assign chan0_pin_oe_out = is_cmp;
    assign count_value_out = st_ff.cnt;
    assign chan0_value_out = st_ff.cc0;
    assign count_down_out = st_ff.dir == t16c_pkg::T16C_DOWN;
    assign count_step_out = step;
    assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask &
                       {chan_irq_mask, 1'b1});

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_low_read;
        hit(reg_rd_in, reg_addr_in, t16c_pkg::ADDR_CNT_LOW);
    endsequence

    sequence s_high_read;
        hit(reg_rd_in, reg_addr_in, t16c_pkg::ADDR_CNT_HIGH);
    endsequence

    a_cnt_clear_write: assert property (
        wr_cnt_low |=> st_ff.cnt == 16'h0000)
        else $error("Counter not cleared by low byte write");

    a_high_byte_latch: assert property (
        s_low_read ##1 s_high_read |=>
            reg_rdata_out == $past(st_ff.cnt[15:8], 2))
        else $error("High byte read does not match low byte read");

    a_ch0_flag_set: assert property (
        ch0_ev |=> st_ff.flags[1] && st_ff.irq_stat[1])
        else $error("Channel 0 flag not set by its event");

    a_flag_one_keeps: assert property (
        hit(reg_wr_in, reg_addr_in, t16c_pkg::ADDR_CTL) &&
        reg_wdata_in[5] && st_ff.flags[1] |=> st_ff.flags[1])
        else $error("Writing one disturbed channel 0 flag");

    a_free_wrap_ovf: assert property (
        step && st_ff.mode == t16c_pkg::MODE_FREE && !wr_cnt_low &&
        st_ff.cnt == 16'hffff |=>
            st_ff.cnt == 16'h0000 && st_ff.flags[0])
        else $error("Free running wrap without overflow");

    a_suspend_holds: assert property (
        st_ff.mode == t16c_pkg::MODE_SUSPEND && !wr_cnt_low
            |=> $stable(st_ff.cnt))
        else $error("Counter moved while suspended");

    a_modulo_restart: assert property (
        step && st_ff.mode == t16c_pkg::MODE_MODULO && !wr_cnt_low &&
        st_ff.cnt == st_ff.cc0 |=> st_ff.cnt == 16'h0000)
        else $error("Modulo mode did not restart at zero");

    a_updown_turn: assert property (
        step && st_ff.mode == t16c_pkg::MODE_UPDOWN && !wr_cnt_low &&
        st_ff.dir == t16c_pkg::T16C_UP && st_ff.cnt == st_ff.cc0 &&
        st_ff.cc0 != 16'h0000 |=>
            count_down_out && st_ff.cnt == $past(st_ff.cc0) - 16'h0001)
        else $error("Up/down counter did not turn at top");

    a_cmp_set_pin: assert property (
        match_ev && cmp_mode == 3'h0 |=> chan0_pin_out)
        else $error("Compare set action did not raise output");

    a_cmp_toggle_pin: assert property (
        match_ev && cmp_mode == 3'h2 |=>
            chan0_pin_out != $past(chan0_pin_out))
        else $error("Compare toggle action did not invert output");

    a_capture_copy: assert property (
        cap_ev |=> chan0_value_out == $past(st_ff.cnt))
        else $error("Capture did not copy the counter");

    a_mask_gates_irq: assert property (
        !chan_irq_mask && !st_ff.irq_stat[0] |-> !irq_out)
        else $error("Interrupt raised while channel masked");

endmodule : t16c_core
`default_nettype wire

// ---- rtl/t16c_pkg.sv ----
// Constants, codes and types shared by the 16-bit timer core files.
// Assumes an 8-bit register port with byte addresses of its own.
package t16c_pkg;

    // Register addresses on the byte port
    localparam logic [7:0] ADDR_CC0_LOW = 8'hda;
    localparam logic [7:0] ADDR_CC0_HIGH = 8'hdb;
    localparam logic [7:0] ADDR_CNT_LOW = 8'he2;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'he3;
    localparam logic [7:0] ADDR_CTL = 8'he4;
    localparam logic [7:0] ADDR_CH0CTL = 8'he5;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hf1;

    // Values after reset, and the counter maximum
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] RST_CH0CTL = 8'h40;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK = 2'h3;

    // Field positions
    localparam int CTL_FLAG_LSB = 4;
    localparam int CTL_DIV_LSB = 2;
    localparam int CTL_MODE_LSB = 0;
    localparam int CH0_IM_BIT = 6;
    localparam int CH0_CMP_LSB = 3;
    localparam int CH0_FUNC_BIT = 2;
    localparam int CH0_CAP_LSB = 0;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_CH0_BIT = 1;

    // Counting modes
    localparam logic [1:0] MODE_SUSPEND = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_MODULO = 2'h2;
    localparam logic [1:0] MODE_UPDOWN = 2'h3;

    // Compare actions
    localparam logic [2:0] CMP_SET = 3'h0;
    localparam logic [2:0] CMP_CLEAR = 3'h1;
    localparam logic [2:0] CMP_TOGGLE = 3'h2;
    localparam logic [2:0] CMP_SET_UP = 3'h3;
    localparam logic [2:0] CMP_CLEAR_UP = 3'h4;

    // Prescaler terminal counts (divider minus one)
    localparam logic [6:0] DIV1_LAST = 7'h00;
    localparam logic [6:0] DIV8_LAST = 7'h07;
    localparam logic [6:0] DIV32_LAST = 7'h1f;
    localparam logic [6:0] DIV128_LAST = 7'h7f;

    typedef enum logic {
        T16C_UP = 1'b0,
        T16C_DOWN = 1'b1
    } t16c_dir_t;

    function automatic logic [6:0] div_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: div_last = DIV1_LAST;
            2'h1: div_last = DIV8_LAST;
            2'h2: div_last = DIV32_LAST;
            2'h3: div_last = DIV128_LAST;
        endcase
    endfunction : div_last

endpackage : t16c_pkg

// ---- rtl/t16c_prescale.sv ----
// Tick prescaler: passes every 1st, 8th, 32nd or 128th tick on.
// Assumes tick_in is a one-cycle pulse from logic on clock_in.
`timescale 1ns/10ps
`default_nettype none
module t16c_prescale (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Control
    input wire logic run_in,
    input wire logic [1:0] div_sel_in,
    input wire logic tick_in,
    // Counter advance pulse
    output logic step_out
);
    typedef struct packed {
        logic [6:0] cnt;
    } t16c_pre_st_t;

    t16c_pre_st_t st_ff;
    t16c_pre_st_t nxt_st;
    logic [6:0] last;

    assign last = t16c_pkg::div_last(div_sel_in);
    assign step_out = run_in && tick_in && (st_ff.cnt >= last);

    always_comb begin
        nxt_st = st_ff;
        if (!run_in) begin
            nxt_st.cnt = 7'h00;
        end else if (tick_in) begin
            // Greater-or-equal keeps a divider change from stalling
            if (st_ff.cnt >= last) begin
                nxt_st.cnt = 7'h00;
            end else begin
                nxt_st.cnt = st_ff.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : t16c_prescale
`default_nettype wire

// ---- rtl/t16c_pin_sync.sv ----
// Two-stage synchroniser with edge detection for the capture pin.
// Assumes the pin is asynchronous to clock_in.
`timescale 1ns/10ps
`default_nettype none
module t16c_pin_sync (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Raw pin
    input wire logic pin_in,
    // Synchronised edges
    output logic rise_out,
    output logic fall_out
);
    typedef struct packed {
        logic [2:0] sr;
    } t16c_sync_st_t;

    t16c_sync_st_t st_ff;
    t16c_sync_st_t nxt_st;

    // Stage 0 feeds only stage 1; edges use stages 1 and 2
    assign rise_out = st_ff.sr[1] && !st_ff.sr[2];
    assign fall_out = !st_ff.sr[1] && st_ff.sr[2];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sr = {st_ff.sr[1:0], pin_in};
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : t16c_pin_sync
`default_nettype wire

// ---- testbench/t16c_pin_model.sv ----
// Far-side model of the channel 0 pin: an external signal source.
// Assumes the core owns the shared pin while its output enable is high.
`timescale 1ns/10ps
`default_nettype none
module t16c_pin_model (
    // Clock
    input wire logic clock_in,
    // Core side of the pin
    input wire logic pin_in,
    input wire logic oe_in,
    // Resolved pin level
    output logic line_out
);
    ////////////////////////////////////////////////////////////////////////
    logic level_ff = 1'b0;

    // Source steps back while the core drives, so no contention is modelled
    assign line_out = oe_in ? pin_in : level_ff;

    task automatic drive(input logic v);
        @(posedge clock_in);
        level_ff <= v;
    endtask : drive
endmodule : t16c_pin_model
`default_nettype wire

// ---- testbench/t16c_core_test.sv ----
// Self-checking bench for the 16-bit timer core with channel 0.
// Assumes a 25 MHz clock and the byte register map of the core.
`timescale 1ns/10ps
`default_nettype none
module t16c_core_test;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tick = 1'b0;
    logic ev1 = 1'b0;
    logic ev2 = 1'b0;
    wire logic [7:0] rdata;
    wire logic pin_out;
    wire logic pin_oe;
    wire logic line;
    wire logic [15:0] cnt;
    wire logic [15:0] val;
    wire logic down;
    wire logic step;
    wire logic irq;
    int n_mismatch = 0;
    int checks_done = 0;

    t16c_core dut_u (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(wr),
        .reg_rd_in(rd),
        .reg_rdata_out(rdata),
        .tick_in(tick),
        .chan1_event_in(ev1),
        .chan2_event_in(ev2),
        .chan0_pin_in(line),
        .chan0_pin_out(pin_out),
        .chan0_pin_oe_out(pin_oe),
        .count_value_out(cnt),
        .chan0_value_out(val),
        .count_down_out(down),
        .count_step_out(step),
        .irq_out(irq)
    );
    t16c_pin_model pm_u (
        .clock_in(clock_in),
        .pin_in(pin_out),
        .oe_in(pin_oe),
        .line_out(line)
    );

    initial begin
        forever #20 clock_in = ~clock_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask : rd_reg

    // Low byte then high byte with no gap between the strobes
    task automatic rd_pair(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clock_in);
        addr <= 8'he2;
        rd <= 1'b1;
        @(posedge clock_in);
        addr <= 8'he3;
        #1;
        chk("rdata", {8'h00, lo}, {8'h00, rdata});
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, hi}, {8'h00, rdata});
    endtask : rd_pair

    // Ticks are spaced so each is a clean one-cycle pulse
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock_in);
            tick <= 1'b1;
            @(posedge clock_in);
            tick <= 1'b0;
        end
        #1;
    endtask : pulse

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clock_in);
        #1;
        chk("irq", {15'h0, e}, {15'h0, irq});
    endtask : irq_is

    // Synchroniser and edge detect need three edges; five leave margin
    task automatic pin(input logic v);
        pm_u.drive(v);
        repeat (5) @(posedge clock_in);
        #1;
    endtask : pin

    ////////////////////////////////////////////////////////////////////////
    task automatic t_free;
        wr_reg(8'he4, 8'h01);
        pulse(300);
        chk("count", 16'h012c, cnt);
        rd_reg(8'he2, 8'h2c);
        pulse(300);
        rd_reg(8'he3, 8'h01);
        rd_pair(8'h58, 8'h02);
        wr_reg(8'he2, 8'h5a);
        chk("count", 16'h0000, cnt);
    endtask : t_free

    task automatic t_div;
        int div_n [4] = '{1, 8, 32, 128};
        logic [15:0] n;
        n = 16'h0000;
        for (int d = 0; d < 4; d++) begin
            wr_reg(8'he4, 8'h00);
            pulse(2);
            chk("count", n, cnt);
            wr_reg(8'he2, 8'h00);
            wr_reg(8'he4, {4'h0, d[1:0], 2'h1});
            pulse(div_n[d] - 1);
            chk("count", 16'h0000, cnt);
            pulse(1);
            chk("count", 16'h0001, cnt);
            n = 16'h0001;
        end
    endtask : t_div

    task automatic t_modulo;
        wr_reg(8'he4, 8'h00);
        wr_reg(8'he2, 8'h00);
        wr_reg(8'hda, 8'h03);
        wr_reg(8'hdb, 8'h00);
        wr_reg(8'he4, 8'h02);
        pulse(3);
        chk("count", 16'h0003, cnt);
        pulse(1);
        chk("count", 16'h0000, cnt);
        rd_reg(8'he4, 8'h12);
        wr_reg(8'he4, 8'hf2);
        rd_reg(8'he4, 8'h12);
        wr_reg(8'he4, 8'h02);
        rd_reg(8'he4, 8'h02);
        wr_reg(8'hf1, 8'h00);
        irq_is(1'b0);
        wr_reg(8'hf1, 8'h03);
        irq_is(1'b1);
        rd_reg(8'hf0, 8'h01);
        irq_is(1'b0);
        rd_reg(8'h00, 8'h00);
    endtask : t_modulo

    task automatic t_updown;
        wr_reg(8'he4, 8'h03);
        pulse(4);
        chk("count", 16'h0002, cnt);
        chk("down", 16'h0001, {15'h0, down});
        pulse(2);
        chk("count", 16'h0000, cnt);
        rd_reg(8'he4, 8'h13);
        rd_reg(8'hf0, 8'h01);
    endtask : t_updown

    task automatic t_events;
        wr_reg(8'he4, 8'h00);
        @(posedge clock_in);
        ev1 <= 1'b1;
        ev2 <= 1'b1;
        @(posedge clock_in);
        ev1 <= 1'b0;
        ev2 <= 1'b0;
        rd_reg(8'he4, 8'hc0);
        wr_reg(8'he4, 8'h00);
        rd_reg(8'he4, 8'h00);
    endtask : t_events

    task automatic t_compare;
        logic [2:0] code [4] = '{3'h0, 3'h5, 3'h1, 3'h2};
        logic pin_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'he4, 8'h00);
            wr_reg(8'he2, 8'h00);
            wr_reg(8'he5, {2'h1, code[i], 3'h4});
            chk("oe", 16'h0001, {15'h0, pin_oe});
            wr_reg(8'he4, 8'h01);
            pulse(3);
            chk("pin", {15'h0, pin_exp[i]}, {15'h0, pin_out});
        end
        // Clear-up mode first, so its match really moves the high pin
        for (int i = 4; i > 2; i--) begin
            wr_reg(8'he4, 8'h00);
            wr_reg(8'he2, 8'h00);
            wr_reg(8'he5, {2'h1, i[2:0], 3'h4});
            wr_reg(8'he4, 8'h02);
            pulse(3);
            chk("pin", {15'h0, i == 3}, {15'h0, pin_out});
            pulse(1);
            chk("pin", {15'h0, i != 3}, {15'h0, pin_out});
        end
        rd_reg(8'hf0, 8'h03);
        wr_reg(8'he4, 8'h00);
        wr_reg(8'he2, 8'h00);
        wr_reg(8'he5, 8'h04);
        wr_reg(8'he4, 8'h01);
        pulse(3);
        irq_is(1'b0);
        wr_reg(8'he5, 8'h44);
        rd_reg(8'he4, 8'h21);
        irq_is(1'b1);
        rd_reg(8'hf0, 8'h02);
    endtask : t_compare

    task automatic t_capture;
        logic [15:0] n;
        logic [15:0] v;
        n = 16'h0000;
        v = 16'h0003;
        wr_reg(8'he4, 8'h00);
        wr_reg(8'he2, 8'h00);
        wr_reg(8'he4, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'he5, {6'h10, c[1:0]});
            chk("oe", 16'h0000, {15'h0, pin_oe});
            pulse(1);
            n++;
            pin(1'b1);
            if (c[0]) v = n;
            chk("value", v, val);
            pulse(1);
            n++;
            pin(1'b0);
            if (c[1]) v = n;
            chk("value", v, val);
        end
    endtask : t_capture

    // Tick held high steps the counter every cycle up to the wrap
    task automatic t_wrap;
        wr_reg(8'he4, 8'h00);
        wr_reg(8'he2, 8'h00);
        @(posedge clock_in);
        tick <= 1'b1;
        @(posedge clock_in);
        #1;
        chk("step", 16'h0000, {15'h0, step});
        wr_reg(8'he4, 8'h01);
        chk("step", 16'h0001, {15'h0, step});
        repeat (65535) @(posedge clock_in);
        tick <= 1'b0;
        #1;
        chk("count", 16'hffff, cnt);
        pulse(1);
        chk("count", 16'h0000, cnt);
        rd_reg(8'he4, 8'h11);
    endtask : t_wrap

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd_reg(8'he4, 8'h00);
        rd_reg(8'he5, 8'h40);
        t_free();
        t_div();
        t_modulo();
        t_updown();
        t_events();
        t_compare();
        t_capture();
        t_wrap();
        final_report();
    end

    // Whole run needs about 67400 cycles, most of them the full wrap
    initial begin
        repeat (90000) @(posedge clock_in);
        n_mismatch++;
        final_report();
    end
endmodule : t16c_core_test
`default_nettype wire
